// [spe_params.svh]
/*
 * constants of the serial program/erase flow: command opcodes and
 * lengths, response codes, memory select values and address map.
 * assumes nothing; holds definitions only.
 */
`ifndef SPE_PARAMS_SVH
`define SPE_PARAMS_SVH

// ----------------------------------------------------------------
// command opcodes (word 0, bits 15:12)
// ----------------------------------------------------------------
`define SPE_OP_READ_DATA 4'h1
`define SPE_OP_READ_CODE 4'h2
`define SPE_OP_PROG_EE_ROW 4'h4
`define SPE_OP_PROG_CFG 4'h6
`define SPE_OP_BULK_ERASE 4'h7
`define SPE_OP_QUERY_BLANK 4'hA

// ----------------------------------------------------------------
// response codes
// ----------------------------------------------------------------
`define SPE_RSP_PASS 4'h1
`define SPE_RSP_FAIL 4'h3
`define SPE_RSP_LEN 16'h0002
`define SPE_RSP_BLANK 8'hF0
`define SPE_RSP_NOT_BLANK 8'h0F

// ----------------------------------------------------------------
// memory select values of the bulk erase command
// ----------------------------------------------------------------
`define SPE_SEL_CODE 3'h0
`define SPE_SEL_EE 3'h1
`define SPE_SEL_FULL_CHIP 3'h3
`define SPE_SEL_EE_BOOT 3'h6

// ----------------------------------------------------------------
// address map, sizes and reset values
// ----------------------------------------------------------------
`define SPE_CFG_BASE 24'hF8_0000
`define SPE_CFG_SPAN 24'h00_000E
`define SPE_ID_BASE 24'hFF_0000
`define SPE_ID_NEXT 24'hFF_0002
`define SPE_ROW_STRIDE 24'h00_0020
`define SPE_EE_ROW_WORDS 16
`define SPE_CFG_REGS 7
`define SPE_BUF_WORDS 19
`define SPE_ERASED 16'hFFFF

`endif

// [spe_pkg.sv]
/*
 * types shared by the serial program/erase flow.
 * assumes nothing of its surroundings.
 */
package spe_pkg;
    // one serial word
    typedef logic [15:0] spe_word_t;
    // command engine states
    typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_EXEC, ST_RESP} spe_state_t;
endpackage

// [spe_link.sv]
/*
 * link-side shifter of the serial program/erase flow: assembles
 * 16-bit words from the data pin and shifts response words out.
 * assumes the programmer clocks the link and that the core holds
 * tx_word steady while tx_req differs from tx_ack.
 */
`timescale 1ns/100ps
`include "spe_params.svh"

module spe_link
    import spe_pkg::*;
(
    // link clock and reset
    input wire logic link_clk,
    input wire logic rstn,
    // pin side
    input wire logic sd_in,
    output logic sd_out,
    output logic sd_oe,
    // core side
    output spe_word_t rx_word,
    output logic rx_tgl,
    input wire spe_word_t tx_word,
    input wire logic tx_req,
    output logic tx_ack
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic req_s1_reg, req_s2_reg; // request synchroniser
    spe_word_t rx_sh_reg, rx_sh_next; // incoming bits
    logic [3:0] rx_cnt_reg, rx_cnt_next; // bits taken
    spe_word_t rx_word_reg, rx_word_next; // finished word
    logic rx_tgl_reg, rx_tgl_next; // word event
    spe_word_t tx_sh_reg, tx_sh_next; // outgoing bits
    logic [3:0] tx_cnt_reg, tx_cnt_next; // bits shown
    logic oe_reg, oe_next; // pin driven
    logic ack_reg, ack_next; // request done

    // ------------------------------------------------------------
    // shifting
    // ------------------------------------------------------------
    // next-state of the half-duplex shifter
    always_comb begin
        rx_sh_next = rx_sh_reg;
        rx_cnt_next = rx_cnt_reg;
        rx_word_next = rx_word_reg;
        rx_tgl_next = rx_tgl_reg;
        tx_sh_next = tx_sh_reg;
        tx_cnt_next = tx_cnt_reg;
        oe_next = oe_reg;
        ack_next = ack_reg;
        if (oe_reg) begin
            if (tx_cnt_reg == 4'hF) begin
                oe_next = 1'b0;
                ack_next = req_s2_reg;
                // edges spent syncing the request are not command bits
                rx_cnt_next = 4'h0;
            end else begin
                tx_sh_next = {tx_sh_reg[14:0], 1'b0};
                tx_cnt_next = tx_cnt_reg + 4'h1;
            end
        end else if (req_s2_reg != ack_reg) begin
            // load response word, show its top bit
            tx_sh_next = tx_word;
            tx_cnt_next = 4'h0;
            oe_next = 1'b1;
        end else begin
            rx_sh_next = {rx_sh_reg[14:0], sd_in};
            rx_cnt_next = rx_cnt_reg + 4'h1;
            if (rx_cnt_reg == 4'hF) begin
                rx_word_next = {rx_sh_reg[14:0], sd_in};
                rx_tgl_next = ~rx_tgl_reg;
            end
        end
    end

    // registers of the link domain
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
            rx_sh_reg <= 16'h0000;
            rx_cnt_reg <= 4'h0;
            rx_word_reg <= 16'h0000;
            rx_tgl_reg <= 1'b0;
            tx_sh_reg <= 16'h0000;
            tx_cnt_reg <= 4'h0;
            oe_reg <= 1'b0;
            ack_reg <= 1'b0;
        end else begin
            req_s1_reg <= tx_req;
            req_s2_reg <= req_s1_reg;
            rx_sh_reg <= rx_sh_next;
            rx_cnt_reg <= rx_cnt_next;
            rx_word_reg <= rx_word_next;
            rx_tgl_reg <= rx_tgl_next;
            tx_sh_reg <= tx_sh_next;
            tx_cnt_reg <= tx_cnt_next;
            oe_reg <= oe_next;
            ack_reg <= ack_next;
        end
    end

    // outputs straight from flip-flops
    assign sd_out = tx_sh_reg[15];
    assign sd_oe = oe_reg;
    assign rx_word = rx_word_reg;
    assign rx_tgl = rx_tgl_reg;
    assign tx_ack = ack_reg;
endmodule

// [spe_flow.sv]
/*
 * device end of the serial program/erase flow: mode entry, the
 * command engine, and the code, data and configuration stores.
 * assumes CLK at 200 MHz and a programmer that owns the link clock.
 */
`timescale 1ns/100ps
`include "spe_params.svh"

// What this block does
// - commands and answers travel over serial pins
// - entry releases all unused I/O pins
// - first serial output toggles while busy
// - full chip erase clears code, EEPROM, protection
// - erased cells read as all ones
// - identification words survive every erase
// - blank query answers blank or not blank
// - data read returns configuration and EEPROM
// - code read returns implemented code memory
// - EEPROM rows hold sixteen 16-bit words
// - EEPROM is 32, 64 or 128 rows
// - one EEPROM row per program command
// - bulk erase answers 0x1700, 0x0002
// - configuration program answers 0x1600, 0x0002
module spe_flow
    import spe_pkg::*;
#(
    parameter int CODE_WORDS = 256, // implemented code words
    parameter int EE_ROWS = 128, // 32, 64 or 128
    parameter int IO_W = 8, // user I/O pins
    parameter logic [6:0] CP_REGS = 7'h38, // code-protect registers
    parameter logic [15:0] DEV_ID = 16'h0A5C, // arbitrary value
    parameter logic [15:0] REV_ID = 16'h0001 // arbitrary value
) (
    // system clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // programming link
    input wire logic PROG_SERIAL_CLOCK_PIN,
    input wire logic PROG_SERIAL_DATA_PIN_I,
    output logic PROG_SERIAL_DATA_PIN_O,
    output logic PROG_SERIAL_DATA_PIN_OE,
    input wire logic MASTER_CLEAR_HV_PIN,
    // user pins
    input wire logic [IO_W-1:0] USER_IO_OE,
    output logic [IO_W-1:0] UNUSED_IO_OE,
    input wire logic USER_SERIAL_OUT,
    output logic FIRST_SERIAL_OUT_PIN,
    // status
    output logic PROG_MODE
);
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    // EEPROM size from row count
    localparam int EE_WORDS = EE_ROWS * `SPE_EE_ROW_WORDS;
    localparam int SCAN_N = (CODE_WORDS > EE_WORDS) ? CODE_WORDS : EE_WORDS;
    localparam int SW = $clog2(SCAN_N + 1);
    localparam logic [23:0] EE_SPAN = 24'(EE_ROWS) * `SPE_ROW_STRIDE;

    // ------------------------------------------------------------
    // crossings
    // ------------------------------------------------------------
    spe_word_t rx_word; // word from link
    logic rx_tgl; // word event, link domain
    logic tx_ack; // response taken, link domain
    logic hv_s1, hv_s2, ck_s1, ck_s2, dt_s1, dt_s2; // entry pins
    logic rx_s1, rx_s2, rx_s3, ack_s1, ack_s2; // handshakes
    logic rx_ev; // one-cycle word event

    // two-flop synchronisers, one edge stage for the word event
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            hv_s1 <= 1'b0;
            hv_s2 <= 1'b0;
            ck_s1 <= 1'b0;
            ck_s2 <= 1'b0;
            dt_s1 <= 1'b0;
            dt_s2 <= 1'b0;
            rx_s1 <= 1'b0;
            rx_s2 <= 1'b0;
            rx_s3 <= 1'b0;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            hv_s1 <= MASTER_CLEAR_HV_PIN;
            hv_s2 <= hv_s1;
            ck_s1 <= PROG_SERIAL_CLOCK_PIN;
            ck_s2 <= ck_s1;
            dt_s1 <= PROG_SERIAL_DATA_PIN_I;
            dt_s2 <= dt_s1;
            rx_s1 <= rx_tgl;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
            ack_s1 <= tx_ack;
            ack_s2 <= ack_s1;
        end
    end
    assign rx_ev = rx_s2 ^ rx_s3;

    // ------------------------------------------------------------
    // engine state
    // ------------------------------------------------------------
    logic mode_reg, mode_next; // programming mode
    logic hv_prev_reg, hv_prev_next; // entry edge
    spe_state_t state_reg, state_next; // engine state
    logic [7:0] widx_reg, widx_next; // words received
    spe_word_t cmd_reg [`SPE_BUF_WORDS]; // command words
    spe_word_t cmd_next [`SPE_BUF_WORDS];
    logic [SW-1:0] scan_reg, scan_next; // erase or blank walk
    logic blank_reg, blank_next; // blank result
    logic ok_reg, ok_next; // command passed
    logic [15:0] ridx_reg, ridx_next; // response word index
    logic [15:0] rlen_reg, rlen_next; // response words
    spe_word_t tx_word_reg, tx_word_next; // word to link
    logic tx_req_reg, tx_req_next; // request toggle
    logic busy_reg, busy_next; // handshake open
    logic sdo_reg, sdo_next; // activity toggle
    spe_word_t code_reg [CODE_WORDS]; // code memory
    spe_word_t code_next [CODE_WORDS];
    spe_word_t ee_reg [EE_WORDS]; // data EEPROM
    spe_word_t ee_next [EE_WORDS];
    spe_word_t cfg_reg [`SPE_CFG_REGS]; // configuration
    spe_word_t cfg_next [`SPE_CFG_REGS];

    // ------------------------------------------------------------
    // response words
    // ------------------------------------------------------------
    // header, length, then read data by index
    function automatic spe_word_t resp_word(input logic [15:0] idx);
        logic [3:0] op;
        logic [23:0] a;
        logic [23:0] c;
        spe_word_t w;
        op = cmd_reg[0][15:12];
        a = {cmd_reg[2][7:0], cmd_reg[3]} + {7'h00, idx - 16'h0002, 1'b0};
        c = a - `SPE_CFG_BASE;
        w = `SPE_ERASED;
        if (idx == 16'h0000) begin
            w = {ok_reg ? `SPE_RSP_PASS : `SPE_RSP_FAIL, op, 8'h00};
            if (op == `SPE_OP_QUERY_BLANK) begin
                w[7:0] = blank_reg ? `SPE_RSP_BLANK : `SPE_RSP_NOT_BLANK;
            end
        end else if (idx == 16'h0001) begin
            w = rlen_reg;
        end else if (op == `SPE_OP_READ_CODE) begin
            if (a[23:1] < 23'(CODE_WORDS)) begin
                w = code_reg[int'(a[23:1])];
            end
        end else if (a == `SPE_ID_BASE) begin
            w = DEV_ID;
        end else if (a == `SPE_ID_NEXT) begin
            w = REV_ID;
        end else if (a >= `SPE_CFG_BASE && c < `SPE_CFG_SPAN) begin
            w = cfg_reg[int'(c[3:1])];
        end else if (a < EE_SPAN) begin
            w = ee_reg[int'(a[23:1])];
        end
        return w;
    endfunction

    // ------------------------------------------------------------
    // command engine
    // ------------------------------------------------------------
    // next values of mode, engine and stores
    always_comb begin
        logic [2:0] sel;
        logic [23:0] addr;
        logic [23:0] coff;
        logic sel_code, sel_ee, sel_cp;
        int row;
        sel = cmd_reg[1][2:0];
        addr = {cmd_reg[1][7:0], cmd_reg[2]};
        coff = addr - `SPE_CFG_BASE;
        row = int'(addr[23:5]);
        sel_ee = (sel != `SPE_SEL_CODE);
        sel_code = (sel != `SPE_SEL_EE) && (sel < `SPE_SEL_EE_BOOT);
        sel_cp = (sel >= `SPE_SEL_FULL_CHIP) && (sel < `SPE_SEL_EE_BOOT);
        mode_next = mode_reg;
        hv_prev_next = hv_s2;
        state_next = state_reg;
        widx_next = widx_reg;
        cmd_next = cmd_reg;
        scan_next = scan_reg;
        blank_next = blank_reg;
        ok_next = ok_reg;
        ridx_next = ridx_reg;
        rlen_next = rlen_reg;
        tx_word_next = tx_word_reg;
        tx_req_next = tx_req_reg;
        busy_next = busy_reg;
        code_next = code_reg;
        ee_next = ee_reg;
        cfg_next = cfg_reg;
        // entry with clock and data high
        if (!hv_s2) begin
            mode_next = 1'b0;
        end else if (!hv_prev_reg && ck_s2 && dt_s2) begin
            mode_next = 1'b1;
        end
        sdo_next = (state_reg != ST_IDLE) ? ~sdo_reg : sdo_reg;
        case (state_reg)
            ST_IDLE: begin
                // first word holds opcode and length
                if (rx_ev && mode_reg) begin
                    cmd_next[0] = rx_word;
                    widx_next = 8'h01;
                    scan_next = '0;
                    blank_next = 1'b1;
                    ok_next = 1'b1;
                    rlen_next = `SPE_RSP_LEN;
                    ridx_next = 16'h0000;
                    state_next = (rx_word[7:0] > 8'h01) ? ST_RECV : ST_EXEC;
                end
            end
            ST_RECV: begin
                if (rx_ev) begin
                    if (widx_reg < 8'(`SPE_BUF_WORDS)) begin
                        cmd_next[int'(widx_reg)] = rx_word;
                    end
                    widx_next = widx_reg + 8'h01;
                    if (widx_reg == cmd_reg[0][7:0] - 8'h01) begin
                        state_next = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                state_next = ST_RESP;
                case (cmd_reg[0][15:12])
                    `SPE_OP_BULK_ERASE: begin
                        if (sel_code && scan_reg < SW'(CODE_WORDS)) begin
                            code_next[int'(scan_reg)] = `SPE_ERASED;
                        end
                        if (sel_ee && scan_reg < SW'(EE_WORDS)) begin
                            ee_next[int'(scan_reg)] = `SPE_ERASED;
                        end
                        if (sel_cp && scan_reg == '0) begin
                            for (int i = 0; i < `SPE_CFG_REGS; i++) begin
                                if (CP_REGS[i]) begin
                                    cfg_next[i] = `SPE_ERASED;
                                end
                            end
                        end
                        scan_next = scan_reg + SW'(1);
                        if (scan_reg != SW'(SCAN_N - 1)) begin
                            state_next = ST_EXEC;
                        end
                    end
                    `SPE_OP_QUERY_BLANK: begin
                        if (scan_reg < SW'(CODE_WORDS)) begin
                            if (code_reg[int'(scan_reg)] != `SPE_ERASED) begin
                                blank_next = 1'b0;
                            end
                        end
                        if (scan_reg < SW'(EE_WORDS)) begin
                            if (ee_reg[int'(scan_reg)] != `SPE_ERASED) begin
                                blank_next = 1'b0;
                            end
                        end
                        scan_next = scan_reg + SW'(1);
                        if (scan_reg != SW'(SCAN_N - 1)) begin
                            state_next = ST_EXEC;
                        end
                    end
                    `SPE_OP_PROG_CFG: begin
                        if (addr >= `SPE_CFG_BASE && coff < `SPE_CFG_SPAN
                            && !coff[0]) begin
                            cfg_next[int'(coff[3:1])] = cmd_reg[3];
                        end else begin
                            ok_next = 1'b0;
                        end
                    end
                    `SPE_OP_PROG_EE_ROW: begin
                        if (addr < EE_SPAN && addr[4:0] == 5'h00) begin
                            for (int j = 0; j < `SPE_EE_ROW_WORDS; j++) begin
                                ee_next[row * `SPE_EE_ROW_WORDS + j] = cmd_reg[3 + j];
                            end
                        end else begin
                            ok_next = 1'b0;
                        end
                    end
                    `SPE_OP_READ_DATA, `SPE_OP_READ_CODE: begin
                        // header, length, then the words asked
                        rlen_next = cmd_reg[1] + `SPE_RSP_LEN;
                    end
                    default: begin
                        ok_next = 1'b0;
                    end
                endcase
            end
            ST_RESP: begin
                if (!busy_reg) begin
                    tx_word_next = resp_word(ridx_reg);
                    tx_req_next = ~tx_req_reg;
                    busy_next = 1'b1;
                end else if (ack_s2 == tx_req_reg) begin
                    busy_next = 1'b0;
                    ridx_next = ridx_reg + 16'h0001;
                    if (ridx_reg == rlen_reg - 16'h0001) begin
                        state_next = ST_IDLE;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // leaving the mode ends a command once the link is quiet
        if (!mode_reg && !busy_reg) begin
            state_next = ST_IDLE;
        end
    end

    // registers of the engine; stores reset to the erased state
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            mode_reg <= 1'b0;
            hv_prev_reg <= 1'b1;
            state_reg <= ST_IDLE;
            widx_reg <= 8'h00;
            for (int k = 0; k < `SPE_BUF_WORDS; k++) begin
                cmd_reg[k] <= 16'h0000;
            end
            scan_reg <= '0;
            blank_reg <= 1'b1;
            ok_reg <= 1'b1;
            ridx_reg <= 16'h0000;
            rlen_reg <= `SPE_RSP_LEN;
            tx_word_reg <= 16'h0000;
            tx_req_reg <= 1'b0;
            busy_reg <= 1'b0;
            sdo_reg <= 1'b0;
            for (int k = 0; k < CODE_WORDS; k++) begin
                code_reg[k] <= `SPE_ERASED;
            end
            for (int k = 0; k < EE_WORDS; k++) begin
                ee_reg[k] <= `SPE_ERASED;
            end
            for (int k = 0; k < `SPE_CFG_REGS; k++) begin
                cfg_reg[k] <= `SPE_ERASED;
            end
        end else begin
            mode_reg <= mode_next;
            hv_prev_reg <= hv_prev_next;
            state_reg <= state_next;
            widx_reg <= widx_next;
            cmd_reg <= cmd_next;
            scan_reg <= scan_next;
            blank_reg <= blank_next;
            ok_reg <= ok_next;
            ridx_reg <= ridx_next;
            rlen_reg <= rlen_next;
            tx_word_reg <= tx_word_next;
            tx_req_reg <= tx_req_next;
            busy_reg <= busy_next;
            sdo_reg <= sdo_next;
            code_reg <= code_next;
            ee_reg <= ee_next;
            cfg_reg <= cfg_next;
        end
    end

    // ------------------------------------------------------------
    // link and pins
    // ------------------------------------------------------------
    // shifter on the programmer's clock
    spe_link u_link (
        .link_clk(PROG_SERIAL_CLOCK_PIN),
        .rstn(RSTN),
        .sd_in(PROG_SERIAL_DATA_PIN_I),
        .sd_out(PROG_SERIAL_DATA_PIN_O),
        .sd_oe(PROG_SERIAL_DATA_PIN_OE),
        .rx_word(rx_word),
        .rx_tgl(rx_tgl),
        .tx_word(tx_word_reg),
        .tx_req(tx_req_reg),
        .tx_ack(tx_ack)
    );

    // user pins released in the mode
    assign UNUSED_IO_OE = mode_reg ? '0 : USER_IO_OE;
    assign FIRST_SERIAL_OUT_PIN = mode_reg ? sdo_reg : USER_SERIAL_OUT;
    assign PROG_MODE = mode_reg;
endmodule

// [spe_flow_checker.sv]
/* port checker of spe_flow, bound at the foot.
   assumes every relation is sampled on CLK. */
`timescale 1ns/100ps
module spe_chk #(parameter int IO_W = 8) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic PROG_SERIAL_CLOCK_PIN,
    input wire logic PROG_SERIAL_DATA_PIN_I,
    input wire logic PROG_SERIAL_DATA_PIN_O,
    input wire logic PROG_SERIAL_DATA_PIN_OE,
    input wire logic MASTER_CLEAR_HV_PIN,
    input wire logic [IO_W-1:0] USER_IO_OE,
    input wire logic [IO_W-1:0] UNUSED_IO_OE,
    input wire logic USER_SERIAL_OUT,
    input wire logic FIRST_SERIAL_OUT_PIN,
    input wire logic PROG_MODE
);
    // ------------------------------------------------
    // relations at the ports
    // ------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    a_io_hiz: assert property (PROG_MODE |-> UNUSED_IO_OE == '0)
        else $error("io enabled in mode");
    a_io_pass: assert property (!PROG_MODE |-> UNUSED_IO_OE == USER_IO_OE)
        else $error("io enable lost");
    a_sdo_pass: assert property (!PROG_MODE |-> FIRST_SERIAL_OUT_PIN == USER_SERIAL_OUT)
        else $error("serial out lost");
    a_entry_pins: assert property ($rose(PROG_MODE) |->
        $past(PROG_SERIAL_CLOCK_PIN, 3) && $past(PROG_SERIAL_DATA_PIN_I, 3))
        else $error("entry without pins high");
    a_entry_delay: assert property ($rose(PROG_MODE) |->
        $past(MASTER_CLEAR_HV_PIN, 3) && !$past(MASTER_CLEAR_HV_PIN, 4))
        else $error("entry delay wrong");
    a_mode_exit: assert property ($fell(MASTER_CLEAR_HV_PIN) |-> ##3 !PROG_MODE)
        else $error("mode kept");
    a_oe_edge: assert property ($changed(PROG_SERIAL_DATA_PIN_OE) |-> PROG_SERIAL_CLOCK_PIN)
        else $error("enable off link edge");
    a_dout_edge: assert property ($changed(PROG_SERIAL_DATA_PIN_O) |-> PROG_SERIAL_CLOCK_PIN)
        else $error("data off link edge");
endmodule
bind spe_flow spe_chk #(.IO_W(IO_W)) u_chk (.*);

// [spe_prog_model.sv]
/* programmer model: owns link clock, data and high voltage.
   assumes the bench resolves the data wire. */
`timescale 1ns/100ps
module spe_prog
    import spe_pkg::*;
(
    output logic lck,
    output logic hv,
    output logic pd,
    input wire logic pin
);
    spe_word_t rsp[$]; // answer words of the last command
    spe_word_t w;
    initial begin
        lck = 1'b1;
        hv = 1'b0;
        pd = 1'b1;
    end
    task enter(input logic d);
        pd = d;
        #100 hv = 1'b1;
        #100;
    endtask
    task leave;
        hv = 1'b0;
        #100;
    endtask
    task send(input spe_word_t v);
        for (int i = 15; i >= 0; i--) begin
            lck = 1'b0;
            pd = v[i];
            #80 lck = 1'b1;
            #80;
        end
    endtask
    // whole command, then each answer word
    task cmd(input spe_word_t c[$], input int n);
        rsp = {};
        foreach (c[i]) send(c[i]);
        pd = ~pd; // released line shows the inverse
        #1500;
        repeat (n) begin
            // two edges sync the request, one loads, 15 shift, one releases
            for (int i = 18; i >= 0; i--) begin
                lck = 1'b0;
                #80 lck = 1'b1;
                #40 if (i > 0 && i < 17) w[i-1] = pin;
                #40;
            end
            rsp.push_back(w);
            #300;
        end
    endtask
endmodule

// [spe_tb.sv]
/* bench of spe_flow with the programmer model.
   assumes the checker binds itself. */
`timescale 1ns/100ps
module tb;
    import spe_pkg::*;
    logic clk = 1'b0, rstn = 1'b1, uso = 1'b0, sdo_q = 1'b0;
    logic [7:0] uoe = 8'h5A;
    logic lck, hv, pd, dout, doe, pm, sdo;
    logic [7:0] ioe;
    wire din = doe ? dout : pd;
    int failures = 0, comparisons = 0, cyc = 0, tog = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) uso <= ~uso;
    spe_prog u_prog (.lck(lck), .hv(hv), .pd(pd), .pin(din));
    // id values are arbitrary
    spe_flow #(.CODE_WORDS(16), .EE_ROWS(2), .DEV_ID(16'h5A3C), .REV_ID(16'h0003)) u_dut (
        .CLK(clk), .RSTN(rstn), .PROG_SERIAL_CLOCK_PIN(lck), .PROG_SERIAL_DATA_PIN_I(din),
        .PROG_SERIAL_DATA_PIN_O(dout), .PROG_SERIAL_DATA_PIN_OE(doe),
        .MASTER_CLEAR_HV_PIN(hv), .USER_IO_OE(uoe), .UNUSED_IO_OE(ioe),
        .USER_SERIAL_OUT(uso), .FIRST_SERIAL_OUT_PIN(sdo), .PROG_MODE(pm));
    always @(posedge clk) begin
        if (pm === 1'b1 && sdo !== sdo_q) tog++;
        sdo_q <= sdo;
        cyc++;
        if (cyc == 90000) begin
            failures++;
            end_of_test();
        end
    end
    task chk(input string n, input spe_word_t e, input spe_word_t g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task run(input string n, input spe_word_t c[$], input spe_word_t e[$]);
        u_prog.cmd(c, e.size());
        foreach (e[i]) chk(n, e[i], u_prog.rsp[i]);
    endtask
    task t_entry;
        chk("io_oe", {8'h00, uoe}, {8'h00, ioe});
        u_prog.enter(1'b0);
        chk("refused", 16'h0000, {15'h0000, pm});
        u_prog.leave();
        u_prog.enter(1'b1);
        chk("mode", 16'h0001, {15'h0000, pm});
        chk("io_hiz", 16'h0000, {8'h00, ioe});
        $display("t_entry done");
    endtask
    task t_prog;
        spe_word_t c[$];
        run("erase", {16'h7002, 16'h0003}, {16'h1700, 16'h0002});
        chk("toggle", 16'h0001, {15'h0000, tog > 0});
        run("cfg0", {16'h6004, 16'h00F8, 16'h0000, 16'hC234}, {16'h1600, 16'h0002});
        run("cfg3", {16'h6004, 16'h00F8, 16'h0006, 16'h0000}, {16'h1600, 16'h0002});
        for (int r = 0; r < 2; r++) begin
            c = {16'h4013, 16'h0000, 16'(r * 32)};
            for (int k = 0; k < 16; k++) c.push_back(16'(r * 16 + k) ^ 16'hA500);
            run("row", c, {16'h1400, 16'h0002});
        end
        run("ee_rd", {16'h1004, 16'h0002, 16'h0000, 16'h003C},
            {16'h1100, 16'h0004, 16'hA51E, 16'hA51F});
        run("not_blank", {16'hA001}, {16'h1A0F, 16'h0002});
        $display("t_prog done");
    endtask
    task t_wipe;
        run("erase", {16'h7002, 16'h0003}, {16'h1700, 16'h0002});
        run("blank", {16'hA001}, {16'h1AF0, 16'h0002});
        run("ee_clr", {16'h1004, 16'h0001, 16'h0000, 16'h0020}, {16'h1100, 16'h0003, 16'hFFFF});
        run("cfg_rd", {16'h1004, 16'h0004, 16'h00F8, 16'h0000},
            {16'h1100, 16'h0006, 16'hC234, 16'hFFFF, 16'hFFFF, 16'hFFFF});
        run("ids", {16'h1004, 16'h0002, 16'h00FF, 16'h0000},
            {16'h1100, 16'h0004, 16'h5A3C, 16'h0003});
        run("code", {16'h2004, 16'h0001, 16'h0000, 16'h001E}, {16'h1200, 16'h0003, 16'hFFFF});
        u_prog.leave();
        uoe = 8'hC3;
        @(posedge clk);
        #1;
        chk("io_back", {8'h00, uoe}, {8'h00, ioe});
        $display("t_wipe done");
    endtask
    task end_of_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        // a real falling edge resets the link domain too
        #1 rstn = 1'b0;
        repeat (2) @(posedge clk);
        #1 rstn = 1'b1;
        @(posedge clk);
        #1;
        t_entry();
        t_prog();
        t_wipe();
        end_of_test();
    end
endmodule
